//--- bench/serial_rx_tx_status_flags_tb.sv
module serial_rx_tx_status_flags_tb
  import srf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] S1 = ADDR_STATUS_ONE, S2 = ADDR_STATUS_TWO, DB = ADDR_DATA_BUFFER;
  logic clk_sys, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rxCharDone, rxNoise, rxFramingFault, rxParityFault, rxBreak, rxLineHigh, rxIdleSeen;
  logic rxStartSeen, rxFalseStart, txShiftReady, txShifting, txPreambleReq, txBreakReq, txLoad;
  logic [8:0] rxChar, txLoadChar;
  logic interfaceEnable, charNineBit, rxEnable, irqError, irqReceiver, irqTransmitter;
  int nFail = 0;
  int samplesChecked = 0;
  assign hready = hreadyout;
  srf_status_top u_srf_status_top (.clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .rxCharDone, .rxChar, .rxNoise,
    .rxFramingFault, .rxParityFault, .rxBreak, .rxLineHigh, .rxIdleSeen, .rxStartSeen,
    .rxFalseStart, .txShiftReady, .txShifting, .txPreambleReq, .txBreakReq, .txLoad,
    .txLoadChar, .interfaceEnable, .charNineBit, .rxEnable, .irqError, .irqReceiver,
    .irqTransmitter);
  srf_far_model u_srf_far_model (.clk_sys, .rxCharDone, .rxChar, .rxNoise, .rxFramingFault,
    .rxParityFault, .rxBreak, .rxLineHigh, .rxIdleSeen, .rxStartSeen, .rxFalseStart,
    .txShiftReady, .txShifting, .txPreambleReq, .txBreakReq, .txLoad, .txLoadChar);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ======
  // Checking and bus access.
  task end_sim;
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    samplesChecked++;
    if (s !== e) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 50);
    r = hrdata[7:0];
    if (n >= 50) begin
      nFail++;
      end_sim();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask
  task rd(input logic [7:0] a);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk($sformatf("reg %h", a), {1'b0, r & m}, {1'b0, e});
  endtask
  // ======
  // Scenarios.
  task t_reset;
    rchk(S1, 8'hFF, 8'hC0);
    rchk(S2, 8'h03, 8'h00);
    rchk(ADDR_CTRL_THREE, 8'h0F, 8'h00);
    rchk(8'h1C, 8'hFF, 8'h00);
    $display("reset test done");
  endtask
  task t_tx;
    int n;
    wr(ADDR_CTRL_ONE, 8'h03);
    chk("enables", {7'h00, interfaceEnable, charNineBit}, 9'h003);
    wr(ADDR_CTRL_THREE, 8'h40);
    rchk(S1, 8'hFF, 8'hC0);
    wr(DB, 8'h5A);
    rchk(S1, 8'hC0, 8'h80);
    chk("loaded char", u_srf_far_model.lastChar, 9'h15A);
    n = 0;
    while (txShifting !== 1'b0 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 40) begin
      nFail++;
      end_sim();
    end
    rchk(S1, 8'hC0, 8'hC0);
    u_srf_far_model.tx_req(1'b1, 1'b0);
    rchk(S1, 8'h40, 8'h00);
    u_srf_far_model.tx_req(1'b0, 1'b1);
    rchk(S1, 8'h40, 8'h00);
    u_srf_far_model.tx_req(1'b0, 1'b0);
    rchk(S1, 8'h40, 8'h40);
    wr(ADDR_CTRL_ONE, 8'h01);
    rchk(S1, 8'h80, 8'h80);
    wr(DB, 8'hA5);
    rchk(S1, 8'h80, 8'h80);
    chk("loaded char 8", u_srf_far_model.lastChar, 9'h0A5);
    wr(ADDR_CTRL_TWO, 8'hC0);
    repeat (2) @(posedge clk_sys);
    chk("irq tx", {8'h00, irqTransmitter}, 9'h001);
    wr(ADDR_CTRL_ONE, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("irq tx off", {8'h00, irqTransmitter}, 9'h000);
    wr(ADDR_CTRL_TWO, 8'h00);
    $display("tx test done");
  endtask
  task t_rx;
    wr(ADDR_CTRL_ONE, 8'h05);
    chk("rx enable", {8'h00, rxEnable}, 9'h001);
    u_srf_far_model.ev(4);
    rchk(S1, 8'h10, 8'h00);
    u_srf_far_model.send(9'h096);
    rchk(S1, 8'h3F, 8'h20);
    rchk(S1, 8'h20, 8'h20);
    rchk(ADDR_CTRL_THREE, 8'h80, 8'h80);
    rchk(DB, 8'hFF, 8'h96);
    rchk(S1, 8'h20, 8'h00);
    u_srf_far_model.ev(4);
    rchk(S1, 8'h10, 8'h10);
    rd(DB);
    u_srf_far_model.ev(4);
    rchk(S1, 8'h10, 8'h00);
    u_srf_far_model.send(9'h011);
    rchk(S1, 8'h28, 8'h20);
    u_srf_far_model.send(9'h022);
    rchk(DB, 8'hFF, 8'h11);
    rchk(S1, 8'h28, 8'h08);
    rchk(DB, 8'hFF, 8'h11);
    rchk(S1, 8'h08, 8'h00);
    wr(ADDR_CTRL_ONE, 8'h07);
    wr(ADDR_CTRL_TWO, 8'h20);
    u_srf_far_model.send(9'h100);
    repeat (2) @(posedge clk_sys);
    chk("irq rx", {8'h00, irqReceiver}, 9'h001);
    rchk(S1, 8'h20, 8'h20);
    rchk(ADDR_CTRL_THREE, 8'h80, 8'h80);
    rchk(DB, 8'hFF, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("irq rx clear", {8'h00, irqReceiver}, 9'h000);
    wr(ADDR_CTRL_TWO, 8'h00);
    $display("rx test done");
  endtask
  task t_err;
    int k;
    wr(ADDR_CTRL_THREE, 8'h0F);
    for (k = 0; k < 3; k++) begin
      u_srf_far_model.ev(k);
      repeat (2) @(posedge clk_sys);
      chk("irq err", {8'h00, irqError}, 9'h001);
      rchk(S1, 8'h07, 8'h04 >> k);
      rd(DB);
      repeat (2) @(posedge clk_sys);
      chk("irq err clear", {8'h00, irqError}, 9'h000);
    end
    wr(ADDR_CTRL_THREE, 8'h00);
    u_srf_far_model.ev(0);
    repeat (2) @(posedge clk_sys);
    chk("irq err masked", {8'h00, irqError}, 9'h000);
    rchk(S1, 8'h04, 8'h04);
    rd(DB);
    $display("error test done");
  endtask
  task t_brk;
    u_srf_far_model.ev(3);
    rchk(S1, 8'h22, 8'h22);
    rchk(S2, 8'h02, 8'h02);
    rchk(ADDR_CTRL_THREE, 8'h80, 8'h00);
    rd(DB);
    u_srf_far_model.ev(3);
    rchk(S2, 8'h02, 8'h00);
    u_srf_far_model.ev(7);
    u_srf_far_model.ev(3);
    rchk(S2, 8'h02, 8'h02);
    u_srf_far_model.ev(5);
    rchk(S2, 8'h01, 8'h01);
    u_srf_far_model.ev(6);
    rchk(S2, 8'h01, 8'h00);
    $display("break test done");
  endtask
  task t_rst;
    wr(ADDR_CTRL_THREE, 8'h4F);
    rd(S1);
    rd(DB);
    u_srf_far_model.send(9'h1C3);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rchk(ADDR_CTRL_THREE, 8'hFF, 8'hC0);
    rchk(DB, 8'hFF, 8'hC3);
    rchk(S1, 8'hFF, 8'hC0);
    $display("reset keep test done");
  endtask
  initial begin
    {hsel, hwrite, rst_b} = 3'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_brk();
    t_rst();
    end_sim();
  end
endmodule

//--- bench/srf_far_model.sv
module srf_far_model (
  // Clock.
  input wire logic clk_sys,
  // Receiver engine events.
  output logic rxCharDone,
  output logic [8:0] rxChar,
  output logic rxNoise,
  output logic rxFramingFault,
  output logic rxParityFault,
  output logic rxBreak,
  output logic rxLineHigh,
  output logic rxIdleSeen,
  output logic rxStartSeen,
  output logic rxFalseStart,
  // Transmitter engine.
  output logic txShiftReady,
  output logic txShifting,
  output logic txPreambleReq,
  output logic txBreakReq,
  input wire logic txLoad,
  input wire logic [8:0] txLoadChar
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] busy;
  logic [8:0] lastChar;
  // The shifter reports busy from the load cycle on, as it would once a byte is queued.
  assign txShifting = txLoad || (busy != 4'h0);
  assign txShiftReady = !txShifting;
  initial begin
    {rxNoise, rxFramingFault, rxParityFault, rxBreak} = 4'h0;
    {rxLineHigh, rxIdleSeen, rxStartSeen, rxFalseStart} = 4'h0;
    busy = 4'h0;
    rxCharDone = 1'b0;
    rxChar = 9'h000;
    txPreambleReq = 1'b0;
    txBreakReq = 1'b0;
  end
  always @(posedge clk_sys) begin
    if (txLoad) begin
      busy <= 4'h8;
      lastChar <= txLoadChar;
    end else if (busy != 4'h0) begin
      busy <= busy - 4'h1;
    end
  end
  task send(input logic [8:0] c);
    rxChar <= c;
    rxCharDone <= 1'b1;
    @(posedge clk_sys);
    rxCharDone <= 1'b0;
    // Outside the valid cycle the lines carry garbage, never the last character.
    rxChar <= ~c;
  endtask
  task put(input int k, input logic v);
    case (k)
      0: rxNoise <= v;
      1: rxFramingFault <= v;
      2: rxParityFault <= v;
      3: rxBreak <= v;
      4: rxIdleSeen <= v;
      5: rxStartSeen <= v;
      6: rxFalseStart <= v;
      default: rxLineHigh <= v;
    endcase
  endtask
  task ev(input int k);
    put(k, 1'b1);
    @(posedge clk_sys);
    put(k, 1'b0);
  endtask
  task tx_req(input logic p, input logic b);
    txPreambleReq <= p;
    txBreakReq <= b;
  endtask
endmodule

//--- bench/srf_status_monitor.sv
module srf_status_monitor (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register bus.
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Transmit side and requests.
  input wire logic txShiftReady,
  input wire logic txLoad,
  input wire logic [8:0] txLoadChar,
  input wire logic interfaceEnable,
  input wire logic charNineBit,
  input wire logic irqError,
  input wire logic irqTransmitter
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ======
  // Bus answer.
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  wait_state_a: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
  wait_once_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  // ======
  // Transmit hand-over.
  load_pulse_a: assert property (txLoad |=> !txLoad)
    else $error("load pulse longer than one cycle");
  load_ready_a: assert property (txLoad |-> $past(txShiftReady) && $past(interfaceEnable))
    else $error("load without ready shifter or enable");
  load_hold_a: assert property (!txLoad |-> $stable(txLoadChar))
    else $error("loaded character changed between loads");
  ninth_eight_a: assert property (txLoad && !charNineBit |-> !txLoadChar[8])
    else $error("ninth bit sent in eight bit mode");
  tx_irq_off_a: assert property (!interfaceEnable ##1 !interfaceEnable |-> !irqTransmitter)
    else $error("transmitter request while disabled");
  cover property (txLoad);
  cover property (irqError);
  cover property (!interfaceEnable ##1 interfaceEnable);
endmodule

bind srf_status_top srf_status_monitor u_srf_status_monitor (.clk_sys, .rst_b, .hsel, .htrans,
  .hready, .hrdata, .hreadyout, .hresp, .txShiftReady, .txLoad, .txLoadChar,
  .interfaceEnable, .charNineBit, .irqError, .irqTransmitter);

//--- design/srf_ahb_slave.sv
module srf_ahb_slave
  import srf_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // AHB-Lite slave side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Register strobes toward the core.
  srf_reg_if.slave regs
);

  typedef struct packed {
    srf_bus_state_t st;
    logic [7:0] addr;
    logic write;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } srf_slave_t;

  srf_slave_t q;
  srf_slave_t d;

  // ==========================================================================
  // Every transfer takes one wait state so that read data leave a flip-flop
  // and each read side effect fires exactly once.
  always_comb begin
    d = q;
    d.resp = 1'b0;
    if (q.st == SRF_BUS_ACCESS) begin
      d.rdata = {24'h00_0000, regs.rdata};
      d.ready = 1'b1;
      d.st = SRF_BUS_RESP;
    end else if (hsel && hready && htrans[1]) begin
      d.addr = haddr[7:0];
      d.write = hwrite;
      d.ready = 1'b0;
      d.st = SRF_BUS_ACCESS;
    end else begin
      d.st = SRF_BUS_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{st: SRF_BUS_IDLE, addr: 8'h00, write: 1'b0, rdata: 32'h0000_0000,
             ready: 1'b1, resp: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign regs.rdEn = (q.st == SRF_BUS_ACCESS) && !q.write;
  assign regs.wrEn = (q.st == SRF_BUS_ACCESS) && q.write;
  assign regs.addr = q.addr;
  assign regs.wdata = hwdata[7:0];
  assign hrdata = q.rdata;
  assign hreadyout = q.ready;
  assign hresp = q.resp;

endmodule

//--- design/srf_pkg.sv
package srf_pkg;

  // ==========================================================================
  // Register byte offsets (one aligned 32-bit word per register).
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h08;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h10;
  localparam logic [7:0] ADDR_DATA_BUFFER = 8'h18;

  // ==========================================================================
  // Control one fields.
  localparam int CTL1_ENABLE = 0;
  localparam int CTL1_CHAR_NINE = 1;
  localparam int CTL1_RX_ENABLE = 2;

  // Control two fields: interrupt enables occupy bits 7 down to 4.
  localparam int CTL2_EN_LSB = 4;
  localparam int IEN_TX_EMPTY = 3;
  localparam int IEN_TX_COMPLETE = 2;
  localparam int IEN_RX_FULL = 1;
  localparam int IEN_IDLE = 0;

  // Control three fields: error enables occupy bits 3 down to 0.
  localparam int CTL3_RX_NINTH = 7;
  localparam int CTL3_TX_NINTH = 6;

  // Status one fields; bits 5 down to 0 also index the receive flag vector.
  localparam int ST1_TX_EMPTY = 7;
  localparam int ST1_TX_COMPLETE = 6;
  localparam int RXF_FULL = 5;
  localparam int RXF_IDLE = 4;
  localparam int RXF_OVERRUN = 3;
  localparam int RXF_NOISE = 2;
  localparam int RXF_FRAMING = 1;
  localparam int RXF_PARITY = 0;

  // Status two fields.
  localparam int ST2_BREAK = 1;
  localparam int ST2_RX_ACTIVE = 0;

  // ==========================================================================
  // Reset values.
  localparam logic [3:0] RST_IRQ_EN = 4'h0;
  localparam logic [3:0] RST_ERR_EN = 4'h0;
  localparam logic [5:0] RST_RX_FLAGS = 6'h00;
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic RST_TX_COMPLETE = 1'b1;

  typedef enum logic [1:0] {
    SRF_BUS_IDLE = 2'b00,
    SRF_BUS_ACCESS = 2'b01,
    SRF_BUS_RESP = 2'b10
  } srf_bus_state_t;

endpackage

//--- design/srf_reg_if.sv
interface srf_reg_if;
  logic rdEn;
  logic wrEn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport slave (
    output rdEn,
    output wrEn,
    output addr,
    output wdata,
    input rdata
  );

  modport core (
    input rdEn,
    input wrEn,
    input addr,
    input wdata,
    output rdata
  );
endinterface

//--- design/srf_status_top.sv
// Operation
// R1 - In 9-bit mode the received ninth bit is stored with the byte; read-only.
// R2 - In 8-bit mode the ninth bit copies received bit 7; reset keeps it.
// R3 - In 9-bit mode tx_ninth_bit goes to the shifter with the byte; reset keeps it.
// R4 - Error interrupt from overrun, noise, framing, parity flags gated by own enables.
// R5 - Handing a byte to the shifter sets tx_empty_flag; interrupt when enabled.
// R6 - Status read with tx_empty_flag set, then buffer write, clears it; reset sets.
// R7 - tx_complete_flag sets when empty and nothing shifts; interrupt when enabled.
// R8 - Queueing data, preamble or break clears tx_complete_flag; reset sets it.
// R9 - Byte moved to buffer sets rx_full_flag; status then data read clears it.
// R10 - Idle line sets idle_flag with optional interrupt; read sequence clears it.
// R11 - Idle may set only after a character sets rx_full after enable or clear.
// R12 - Character arriving while rx_full is set sets overrun and is discarded.
// R13 - Data read clears overrun only if it was set at the last status read.
// R14 - Noise sets noise_flag; status then data read clears it; reset clears it.
// R15 - Zero stop bit sets framing_fault_flag; read sequence clears it.
// R16 - Parity mismatch sets parity_fault_flag; read sequence clears it.
// R17 - Break sets break, framing and rx_full flags; clears ninth bit in 9-bit mode.
// R18 - Break never interrupts; status two then data read clears it; rearm on ones.
// R19 - Start zero in first sample slot sets rx_active; false start or idle clears.
// R20 - Data buffer at 0x18: read received byte, write transmit byte, reset keeps.
// R21 - Latency-bound software should reread status one after the data read.
// R22 - Receive flags hold until their clearing sequence; status reads alone never clear.
// R23 - Character-length bit selects 8-bit or 9-bit behaviour of ninth-bit fields.
// R24 - Disabling sets tx_empty and tx_complete and blocks transmitter interrupts.
module srf_status_top
  import srf_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // AHB-Lite register bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Receiver engine events.
  input wire logic rxCharDone,
  input wire logic [8:0] rxChar,
  input wire logic rxNoise,
  input wire logic rxFramingFault,
  input wire logic rxParityFault,
  input wire logic rxBreak,
  input wire logic rxLineHigh,
  input wire logic rxIdleSeen,
  input wire logic rxStartSeen,
  input wire logic rxFalseStart,
  // Transmitter engine handshake.
  input wire logic txShiftReady,
  input wire logic txShifting,
  input wire logic txPreambleReq,
  input wire logic txBreakReq,
  output logic txLoad,
  output logic [8:0] txLoadChar,
  // Configuration toward the engines.
  output logic interfaceEnable,
  output logic charNineBit,
  output logic rxEnable,
  // Interrupt requests.
  output logic irqError,
  output logic irqReceiver,
  output logic irqTransmitter
);

  typedef struct packed {
    logic enable;
    logic char9;
    logic rxEn;
    logic [3:0] irqEn;
    logic txNinth;
    logic [3:0] errEn;
    logic [7:0] rxByte;
    logic rxNinth;
    logic [7:0] txByte;
    logic txPending;
    logic txEmpty;
    logic txComplete;
    logic [5:0] rxFlags;
    logic brk;
    logic rxActive;
    logic idleAllowed;
    logic breakRearm;
    logic [7:0] armS1;
    logic armBrk;
    logic txLoad;
    logic [8:0] txLoadChar;
    logic irqErr;
    logic irqRx;
    logic irqTx;
  } srf_core_t;

  srf_core_t q;
  srf_core_t d;
  srf_reg_if regs ();

  logic [7:0] statusOne;
  logic [7:0] statusTwo;

  // ==========================================================================
  // Bus front end.
  srf_ahb_slave u_slave (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .regs(regs.slave)
  );

  // ==========================================================================
  // Read multiplexer.
  assign statusOne = {q.txEmpty, q.txComplete, q.rxFlags};
  assign statusTwo = {6'h00, q.brk, q.rxActive};

  // Unmapped offsets read as zero so that a stray access never sees a stale value.
  always_comb begin
    case (regs.addr)
      ADDR_CTRL_ONE: begin
        regs.rdata = {5'h00, q.rxEn, q.char9, q.enable}; // R23
      end
      ADDR_CTRL_TWO: begin
        regs.rdata = {q.irqEn, 4'h0};
      end
      ADDR_CTRL_THREE: begin
        regs.rdata = {q.rxNinth, q.txNinth, 2'h0, q.errEn}; // R1
      end
      ADDR_STATUS_ONE: begin
        regs.rdata = statusOne;
      end
      ADDR_STATUS_TWO: begin
        regs.rdata = statusTwo;
      end
      ADDR_DATA_BUFFER: begin
        regs.rdata = q.rxByte; // R20
      end
      default: begin
        regs.rdata = 8'h00;
      end
    endcase
  end

  // ==========================================================================
  // Flag and buffer logic. Clears are applied first and sets afterwards, so an
  // event landing in the clearing cycle survives, except an idle event in the cycle that clears idle_flag.
  always_comb begin
    logic dataRd;
    logic dataWr;
    logic statusOneRd;
    logic statusTwoRd;
    logic queued;
    dataRd = regs.rdEn && (regs.addr == ADDR_DATA_BUFFER);
    dataWr = regs.wrEn && (regs.addr == ADDR_DATA_BUFFER);
    statusOneRd = regs.rdEn && (regs.addr == ADDR_STATUS_ONE);
    statusTwoRd = regs.rdEn && (regs.addr == ADDR_STATUS_TWO);
    queued = 1'b0;
    d = q;
    d.txLoad = 1'b0;

    if (regs.wrEn) begin
      case (regs.addr)
        ADDR_CTRL_ONE: begin
          d.enable = regs.wdata[CTL1_ENABLE];
          d.char9 = regs.wdata[CTL1_CHAR_NINE]; // R23
          d.rxEn = regs.wdata[CTL1_RX_ENABLE];
          if (regs.wdata[CTL1_RX_ENABLE] && !q.rxEn) begin
            d.idleAllowed = 1'b0; // R11
          end
        end
        ADDR_CTRL_TWO: d.irqEn = regs.wdata[CTL2_EN_LSB +: 4];
        ADDR_CTRL_THREE: begin
          d.txNinth = regs.wdata[CTL3_TX_NINTH];
          d.errEn = regs.wdata[3:0];
        end
        ADDR_DATA_BUFFER: begin
          d.txByte = regs.wdata; // R20
          d.txPending = 1'b1;
          if (q.armS1[ST1_TX_EMPTY]) begin
            d.txEmpty = 1'b0; // R6
          end
          d.armS1[ST1_TX_EMPTY] = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // A status read only takes a snapshot; nothing is cleared by it alone.
    if (statusOneRd) begin
      d.armS1 = statusOne; // R22
    end
    if (statusTwoRd) begin
      d.armBrk = q.brk;
    end
    if (dataRd) begin
      d.rxFlags = q.rxFlags & ~q.armS1[5:0]; // R9 R10 R13 R14 R15 R16
      if (q.armS1[RXF_IDLE]) begin
        d.idleAllowed = 1'b0; // R11
      end
      d.armS1[5:0] = 6'h00;
      if (q.armBrk) begin
        d.brk = 1'b0; // R18
      end
      d.armBrk = 1'b0;
    end

    // Hand-over to the shifter; a write in the same cycle waits one cycle.
    // Loading the byte that is being written would race the write itself.
    if (q.enable && q.txPending && txShiftReady && !dataWr) begin
      d.txLoad = 1'b1;
      d.txLoadChar = {q.char9 & q.txNinth, q.txByte}; // R3
      d.txPending = 1'b0;
      d.txEmpty = 1'b1; // R5
    end

    // Overrun is judged after this cycle's clear, so a clearing read never loses a byte.
    if (rxCharDone) begin
      if (d.rxFlags[RXF_FULL]) begin
        d.rxFlags[RXF_OVERRUN] = 1'b1; // R12
      end else begin
        d.rxByte = rxChar[7:0];
        d.rxNinth = q.char9 ? rxChar[8] : rxChar[7]; // R1 R2
        d.rxFlags[RXF_FULL] = 1'b1; // R9
        d.idleAllowed = 1'b1; // R11
      end
    end
    if (rxNoise) begin
      d.rxFlags[RXF_NOISE] = 1'b1; // R14
    end
    if (rxFramingFault) begin
      d.rxFlags[RXF_FRAMING] = 1'b1; // R15
    end
    if (rxParityFault) begin
      d.rxFlags[RXF_PARITY] = 1'b1; // R16
    end

    // The flag may only come back after the line has returned to ones.
    if (rxLineHigh) begin
      d.breakRearm = 1'b1; // R18
    end
    if (rxBreak && q.breakRearm) begin
      d.brk = 1'b1; // R17
      d.breakRearm = 1'b0;
      d.rxFlags[RXF_FRAMING] = 1'b1; // R17
      d.rxFlags[RXF_FULL] = 1'b1; // R17
      if (q.char9) begin
        d.rxNinth = 1'b0; // R17
      end
    end

    if (rxIdleSeen && d.idleAllowed) begin
      d.rxFlags[RXF_IDLE] = 1'b1; // R10
    end

    if (rxFalseStart || rxIdleSeen || rxCharDone) begin
      d.rxActive = 1'b0; // R19
    end
    if (rxStartSeen) begin
      d.rxActive = 1'b1; // R19
    end

    // A byte in its load cycle or just handed over counts as queued, so the flag
    // drops at once and never flickers before the shifter reports busy.
    queued = d.txPending || d.txLoad || q.txLoad || txPreambleReq || txBreakReq; // R8
    d.txComplete = d.txEmpty && !txShifting && !queued; // R7

    if (!d.enable) begin
      d.txEmpty = 1'b1; // R24
      d.txComplete = 1'b1; // R24
      d.txPending = 1'b0;
    end

    // Requests follow the next-state flags so that they rise with them.
    d.irqErr = |(d.rxFlags[3:0] & d.errEn); // R4
    d.irqRx = 1'b0;
    if (d.rxFlags[RXF_FULL] && d.irqEn[IEN_RX_FULL]) begin
      d.irqRx = 1'b1; // R9
    end
    if (d.rxFlags[RXF_IDLE] && d.irqEn[IEN_IDLE]) begin
      d.irqRx = 1'b1; // R10
    end
    d.irqTx = 1'b0;
    if (d.txEmpty && d.irqEn[IEN_TX_EMPTY]) begin
      d.irqTx = 1'b1; // R5
    end
    if (d.txComplete && d.irqEn[IEN_TX_COMPLETE]) begin
      d.irqTx = 1'b1; // R7
    end
    if (!d.enable) begin
      d.irqTx = 1'b0; // R24
    end
  end

  // ==========================================================================
  // Buffers and ninth bits are deliberately left out of the reset branch so
  // that they keep their contents across a reset.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q.enable <= 1'b0;
      q.char9 <= 1'b0;
      q.rxEn <= 1'b0;
      q.irqEn <= RST_IRQ_EN;
      q.errEn <= RST_ERR_EN; // R4
      q.txPending <= 1'b0;
      q.txEmpty <= RST_TX_EMPTY; // R6
      q.txComplete <= RST_TX_COMPLETE; // R8
      q.rxFlags <= RST_RX_FLAGS;
      q.brk <= 1'b0;
      q.rxActive <= 1'b0;
      q.idleAllowed <= 1'b0;
      q.breakRearm <= 1'b1;
      q.armS1 <= 8'h00;
      q.armBrk <= 1'b0;
      q.txLoad <= 1'b0;
      q.txLoadChar <= 9'h000;
      q.irqErr <= 1'b0;
      q.irqRx <= 1'b0;
      q.irqTx <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign txLoad = q.txLoad;
  assign txLoadChar = q.txLoadChar;
  assign interfaceEnable = q.enable;
  assign charNineBit = q.char9;
  assign rxEnable = q.rxEn;
  assign irqError = q.irqErr;
  assign irqReceiver = q.irqRx;
  assign irqTransmitter = q.irqTx;

endmodule
